// ### rtl/srg_top.sv
// reference pulse generator with clock channel and reference phase delay, apb register slave
`default_nettype none
`include "srg_map.svh"
module srg_top
  import srg_pkg::*;
#(
  parameter int NUM_CH  = 4,
  parameter int NUM_REF = 4
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 vco_tick,
  input  wire logic                 vcxo_tick,
  input  wire logic                 ext_trigger_pin,
  input  wire logic                 clk3_in,
  output logic                      clk3_to_pll_en,
  output logic      [NUM_CH-1:0]    channel_clock_out,
  output logic      [NUM_REF-1:0]   ref_pulse_out,
  output logic      [NUM_REF-1:0]   ref_out_enable,
  output logic      [NUM_REF-1:0]   ref_crosspoint_bias,
  output logic      [NUM_REF*3-1:0] ref_fine_code
);

  // divider value 0 behaves as 1 so that no counter ever stalls
  function automatic logic [7:0] ndiv(input logic [7:0] v);
    ndiv = (v == 8'h00) ? 8'h01 : v;
  endfunction

  // high phase length of a divided clock, the odd cycle goes to the high phase
  function automatic logic [7:0] hi_len(input logic [7:0] v);
    hi_len = ndiv(v) - (ndiv(v) >> 1);
  endfunction

  // nominal fine delay in picoseconds for readback; note the 10 ps step from 75 to 85
  function automatic logic [7:0] fine_ps(input logic [2:0] code);
    unique case (code)
      3'h0:    fine_ps = 8'h00;
      3'h1:    fine_ps = 8'h19;
      3'h2:    fine_ps = 8'h32;
      3'h3:    fine_ps = 8'h4B;
      3'h4:    fine_ps = 8'h55;
      3'h5:    fine_ps = 8'h6E;
      3'h6:    fine_ps = 8'h87;
      default: fine_ps = 8'hA0;
    endcase
  endfunction

  // ---------------- configuration registers ----------------
  logic            bypass_reg;
  logic            ref_gen_source_sel;
  logic            ref_pulse_mode_sel;
  logic            ext_trigger_input_sel;
  logic            bias_type_reg;
  logic [7:0]      ref_rate_divider;
  logic [7:0]      ref_pulse_count;
  logic [5:0]      sync_div_reg;
  logic [7:0]      gdly_reg;
  srg_byte_t       ch_div_reg   [NUM_CH];
  srg_byte_t       ch_phase_reg [NUM_CH];
  logic [2:0]      coarse_reg   [NUM_REF];
  logic [2:0]      fine_reg     [NUM_REF];
  logic            idle_bias_ctrl     [NUM_REF];
  logic            ref_output_mux_sel [NUM_REF];

  // ---------------- apb decode ----------------
  wire       setup_ph   = psel & ~penable;
  wire       wr_en      = psel & penable & pwrite & pready;
  wire [1:0] idx        = paddr[3:2];
  wire       hit_ctrl   = (paddr == `SRG_OFF_CTRL);
  wire       hit_cfg    = (paddr == `SRG_OFF_REFCFG);
  wire       hit_stat   = (paddr == `SRG_OFF_STATUS);
  wire       hit_ch     = (paddr[7:4] == `SRG_PAGE_CH) & (32'(idx) < NUM_CH);
  wire       hit_ref    = (paddr[7:4] == `SRG_PAGE_REF) & (32'(idx) < NUM_REF);
  wire       addr_hit   = hit_ctrl | hit_cfg | hit_stat | hit_ch | hit_ref;
  wire       release_wr = wr_en & hit_ctrl & pwdata[`SRG_CTRL_RELEASE];
  wire       stop_wr    = wr_en & hit_ctrl & pwdata[`SRG_CTRL_STOP];
  wire       restart_wr = wr_en & hit_ctrl & pwdata[`SRG_CTRL_RESTART];

  // configuration writes; everything delay related clears to zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bypass_reg            <= 1'b0;
      ref_gen_source_sel    <= 1'b0;
      ref_pulse_mode_sel    <= 1'b0;
      ext_trigger_input_sel <= 1'b0;
      bias_type_reg         <= 1'b0;
      ref_rate_divider      <= `SRG_RST_RATE;
      ref_pulse_count       <= `SRG_RST_COUNT;
      sync_div_reg          <= `SRG_RST_SYNC;
      gdly_reg              <= `SRG_RST_DELAY;
      for (int i = 0; i < NUM_CH; i++) begin
        ch_div_reg[i]   <= `SRG_RST_DIV;
        ch_phase_reg[i] <= `SRG_RST_DELAY;
      end
      for (int i = 0; i < NUM_REF; i++) begin
        coarse_reg[i]         <= 3'h0;
        fine_reg[i]           <= 3'h0;
        idle_bias_ctrl[i]     <= 1'b0;
        ref_output_mux_sel[i] <= 1'b0;
      end
    end else if (wr_en) begin
      if (hit_ctrl) begin
        bypass_reg            <= pwdata[`SRG_CTRL_BYPASS];
        ref_gen_source_sel    <= pwdata[`SRG_CTRL_SOURCE];
        ref_pulse_mode_sel    <= pwdata[`SRG_CTRL_MODE];
        ext_trigger_input_sel <= pwdata[`SRG_CTRL_INSEL];
        bias_type_reg         <= pwdata[`SRG_CTRL_BIASTYPE];
      end
      if (hit_cfg) begin
        ref_rate_divider <= pwdata[`SRG_CFG_RATE_LSB +: 8];
        ref_pulse_count  <= pwdata[`SRG_CFG_COUNT_LSB +: 8];
        sync_div_reg     <= pwdata[`SRG_CFG_SYNC_LSB +: 6];
        gdly_reg         <= pwdata[`SRG_CFG_GDLY_LSB +: 8];
      end
      if (hit_ch) begin
        ch_div_reg[idx]   <= pwdata[7:0];
        ch_phase_reg[idx] <= pwdata[15:8];
      end
      if (hit_ref) begin
        coarse_reg[idx]         <= pwdata[`SRG_REF_COARSE_LSB +: 3];
        fine_reg[idx]           <= pwdata[`SRG_REF_FINE_LSB +: 3];
        idle_bias_ctrl[idx]     <= pwdata[`SRG_REF_BIAS];
        ref_output_mux_sel[idx] <= pwdata[`SRG_REF_MUX];
      end
    end
  end

  // ---------------- delay unit and channel clocks ----------------
  // every delay and divider advances on one oscillator-period tick
  wire unit_tick = bypass_reg ? vcxo_tick : vco_tick;

  logic [7:0] ch_wait  [NUM_CH];
  logic [7:0] ch_cnt   [NUM_CH];
  logic       ch_run   [NUM_CH];
  logic [6:0] sync_cnt;

  // sync period is twice the sync divider, the common period of all channels
  wire [6:0] sync_last = {sync_div_reg, 1'b0} - 7'h01;
  wire       sync_zero = (sync_div_reg == 6'h00);
  wire       coinc     = unit_tick & (sync_cnt == 7'h00);
  // phase delay holds a channel off for ch_phase ticks after a restart, so a
  // delay of half the divider shifts it by half a period, which is its inverse
  always_ff @(posedge clk) begin
    if (!rst_n || restart_wr) begin
      for (int i = 0; i < NUM_CH; i++) begin
        ch_wait[i] <= restart_wr ? ch_phase_reg[i] : `SRG_RST_DELAY;
        ch_cnt[i]  <= 8'h00;
        ch_run[i]  <= 1'b0;
      end
    end else if (unit_tick) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (!ch_run[i]) begin
          if (ch_wait[i] == 8'h00) ch_run[i] <= 1'b1;
          else ch_wait[i] <= ch_wait[i] - 8'h01;
        end else if (ch_cnt[i] == ndiv(ch_div_reg[i]) - 8'h01) begin
          ch_cnt[i] <= 8'h00;
        end else begin
          ch_cnt[i] <= ch_cnt[i] + 8'h01;
        end
      end
    end
  end

  // sync counter restarts together with the channels so that its zero marks
  // the rising edges they all share
  always_ff @(posedge clk) begin
    if (!rst_n || restart_wr) begin
      sync_cnt <= 7'h00;
    end else if (unit_tick) begin
      if (sync_zero || sync_cnt == sync_last) sync_cnt <= 7'h00;
      else sync_cnt <= sync_cnt + 7'h01;
    end
  end

  logic [NUM_CH-1:0] ch_level;
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      ch_level[i] = ch_run[i] & (ch_cnt[i] < hi_len(ch_div_reg[i]));
    end
  end

  // ---------------- external trigger ----------------
  logic trig_s1;
  logic trig_s2;
  logic trig_s3;
  wire  trig_raw  = ext_trigger_input_sel ? clk3_in : ext_trigger_pin;
  wire  trig_rise = trig_s2 & ~trig_s3;

  // two stage synchroniser, the edge detector compares the second stage with its delayed copy trig_s3
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      trig_s3 <= 1'b0;
    end else begin
      trig_s1 <= trig_raw;
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
    end
  end

  // ---------------- event sequencer ----------------
  srg_state_e state_reg;
  srg_state_e state_next;
  logic [7:0] remain_reg;
  logic [7:0] rate_cnt;
  logic [8:0] gdly_cnt;

  wire rate_wrap  = unit_tick & (rate_cnt == ndiv(ref_rate_divider) - 8'h01);
  wire last_pulse = ~ref_pulse_mode_sel & (remain_reg == 8'h01);
  wire gdly_done  = unit_tick & (gdly_cnt == 9'h000);
  wire ref_raw    = (state_reg == SRG_RUN) & (rate_cnt < hi_len(ref_rate_divider));
  wire ref_active = (state_reg == SRG_RUN);

  // release arms; internal source goes straight on to the sync wait, the
  // external one waits for its trigger edge; a release while busy is ignored
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SRG_IDLE:
        if (release_wr) state_next = ref_gen_source_sel ? SRG_ARMED : SRG_SYNC;
      SRG_ARMED:
        if (trig_rise) state_next = SRG_SYNC;
      SRG_SYNC:
        if (coinc) state_next = SRG_GDLY;
      SRG_GDLY:
        if (gdly_done) state_next = SRG_RUN;
      SRG_RUN:
        if (rate_wrap && last_pulse) state_next = SRG_IDLE;
      default:
        state_next = SRG_IDLE;
    endcase
    if (stop_wr) state_next = SRG_IDLE;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) state_reg <= SRG_IDLE;
    else state_reg <= state_next;
  end

  // pulse count is captured at release; zero is taken as one pulse
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      remain_reg <= 8'h00;
    end else if (state_reg == SRG_IDLE && release_wr) begin
      remain_reg <= ndiv(ref_pulse_count);
    end else if (ref_active && rate_wrap && !ref_pulse_mode_sel) begin
      remain_reg <= remain_reg - 8'h01;
    end
  end

  // global delay counts two ticks per step from the coincident edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gdly_cnt <= 9'h000;
    end else if (state_reg == SRG_SYNC) begin
      gdly_cnt <= 9'({gdly_reg, 1'b0});
    end else if (state_reg == SRG_GDLY && unit_tick && gdly_cnt != 9'h000) begin
      gdly_cnt <= gdly_cnt - 9'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || state_reg != SRG_RUN) begin
      rate_cnt <= 8'h00;
    end else if (rate_wrap) begin
      rate_cnt <= 8'h00;
    end else if (unit_tick) begin
      rate_cnt <= rate_cnt + 8'h01;
    end
  end

  // ---------------- per output coarse delay and output stage ----------------
  logic [`SRG_COARSE_TAPS-1:0] pulse_line [NUM_REF];
  logic [`SRG_COARSE_TAPS-1:0] act_line   [NUM_REF];

  // tap 0 is the signal registered on one tick; each further tap adds one oscillator period
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int r = 0; r < NUM_REF; r++) begin
        pulse_line[r] <= '0;
        act_line[r]   <= '0;
      end
    end else if (unit_tick) begin
      for (int r = 0; r < NUM_REF; r++) begin
        pulse_line[r] <= {pulse_line[r][`SRG_COARSE_TAPS-2:0], ref_raw};
        act_line[r]   <= {act_line[r][`SRG_COARSE_TAPS-2:0], ref_active};
      end
    end
  end

  logic [NUM_REF-1:0] tap_pulse;
  logic [NUM_REF-1:0] tap_act;
  always_comb begin
    for (int r = 0; r < NUM_REF; r++) begin
      tap_pulse[r] = pulse_line[r][coarse_reg[r]];
      tap_act[r]   = act_line[r][coarse_reg[r]];
    end
  end

  // all outputs are registered; a clock-mode reference output reuses its channel
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      channel_clock_out   <= '0;
      ref_pulse_out       <= '0;
      ref_out_enable      <= '0;
      ref_crosspoint_bias <= '0;
      ref_fine_code       <= '0;
      clk3_to_pll_en      <= 1'b1;
    end else begin
      channel_clock_out <= ch_level;
      clk3_to_pll_en    <= ~ext_trigger_input_sel;
      for (int r = 0; r < NUM_REF; r++) begin
        if (ref_output_mux_sel[r]) begin
          ref_pulse_out[r]       <= tap_pulse[r] & tap_act[r];
          ref_out_enable[r]      <= tap_act[r];
          ref_crosspoint_bias[r] <= ~tap_act[r] & idle_bias_ctrl[r] & bias_type_reg;
        end else begin
          ref_pulse_out[r]       <= ch_level[r % NUM_CH];
          ref_out_enable[r]      <= 1'b1;
          ref_crosspoint_bias[r] <= 1'b0;
        end
        ref_fine_code[r*3 +: 3] <= fine_reg[r];
      end
    end
  end

  // ---------------- apb read and answer ----------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_mux[`SRG_CTRL_BYPASS]   = bypass_reg;
      rd_mux[`SRG_CTRL_SOURCE]   = ref_gen_source_sel;
      rd_mux[`SRG_CTRL_MODE]     = ref_pulse_mode_sel;
      rd_mux[`SRG_CTRL_INSEL]    = ext_trigger_input_sel;
      rd_mux[`SRG_CTRL_BIASTYPE] = bias_type_reg;
    end
    if (hit_cfg) begin
      rd_mux = {2'b00, gdly_reg, sync_div_reg, ref_pulse_count, ref_rate_divider};
    end
    if (hit_stat) begin
      rd_mux = {16'h0000, remain_reg, 5'h00, state_reg};
    end
    if (hit_ch) begin
      rd_mux = {16'h0000, ch_phase_reg[idx], ch_div_reg[idx]};
    end
    if (hit_ref) begin
      rd_mux = {16'h0000, fine_ps(fine_reg[idx]), ref_output_mux_sel[idx],
                idle_bias_ctrl[idx], fine_reg[idx], coarse_reg[idx]};
    end
  end

  // zero wait state: ready rises in the access cycle after every setup cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup_ph;
      pslverr <= setup_ph & ~addr_hit;
      if (setup_ph) prdata <= (addr_hit && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// ### rtl/srg_map.svh
// register offsets, field positions, reset values and timing constants of the reference pulse generator
`ifndef SRG_MAP_SVH
`define SRG_MAP_SVH

`define SRG_OFF_CTRL      8'h00
`define SRG_OFF_REFCFG    8'h04
`define SRG_OFF_STATUS    8'h08
`define SRG_PAGE_CH       4'h1
`define SRG_PAGE_REF      4'h2

`define SRG_CTRL_BYPASS   0
`define SRG_CTRL_SOURCE   1
`define SRG_CTRL_MODE     2
`define SRG_CTRL_INSEL    3
`define SRG_CTRL_BIASTYPE 4
`define SRG_CTRL_RESTART  5
`define SRG_CTRL_RELEASE  8
`define SRG_CTRL_STOP     9

`define SRG_CFG_RATE_LSB  0
`define SRG_CFG_COUNT_LSB 8
`define SRG_CFG_SYNC_LSB  16
`define SRG_CFG_GDLY_LSB  22

`define SRG_REF_COARSE_LSB 0
`define SRG_REF_FINE_LSB   3
`define SRG_REF_BIAS       6
`define SRG_REF_MUX        7
`define SRG_REF_PS_LSB     8

`define SRG_RST_DELAY     8'h00
`define SRG_RST_DIV       8'h01
`define SRG_RST_RATE      8'h02
`define SRG_RST_COUNT     8'h01
`define SRG_RST_SYNC      6'h01
`define SRG_COARSE_TAPS   8
`define SRG_GDLY_STEP     2

`endif

// ### rtl/srg_pkg.sv
// types shared by the reference pulse generator
`default_nettype none
package srg_pkg;
  typedef enum logic [2:0] {
    SRG_IDLE  = 3'b000,
    SRG_ARMED = 3'b001,
    SRG_SYNC  = 3'b010,
    SRG_GDLY  = 3'b011,
    SRG_RUN   = 3'b100
  } srg_state_e;
  typedef logic [7:0] srg_byte_t;
endpackage
`default_nettype wire

// ### tb/srg_assertions.sv
// port-level checks of the reference pulse generator
`default_nettype none
module srg_assertions
  import srg_pkg::*;
#(
  parameter int NUM_CH  = 4,
  parameter int NUM_REF = 4
) (
  input wire logic                 clk,
  input wire logic                 rst_n,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic [7:0]           paddr,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic                 clk3_to_pll_en,
  input wire logic [NUM_REF-1:0]   ref_pulse_out,
  input wire logic [NUM_REF-1:0]   ref_out_enable,
  input wire logic [NUM_REF-1:0]   ref_crosspoint_bias,
  input wire logic [NUM_REF*3-1:0] ref_fine_code
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // the two phases of a bus transfer
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  property p_ready_once;
    s_setup |=> pready ##1 !pready;
  endproperty
  a_ready_once: assert property (p_ready_once) else $error("pready not single cycle after setup");
  property p_ready_cause;
    pready |-> psel && penable && $past(psel && !penable);
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("pready without prior setup");
  property p_err_answer;
    pslverr |-> s_access ##0 (prdata == 32'h0);
  endproperty
  a_err_answer: assert property (p_err_answer) else $error("error answer malformed");
  property p_err_unmapped;
    s_setup ##0 (paddr == 8'h40) |=> pslverr;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");
  property p_mapped_ok;
    s_setup ##0 (paddr == 8'h04) |=> pready && !pslverr;
  endproperty
  a_mapped_ok: assert property (p_mapped_ok) else $error("mapped access refused");
  // an undriven output must never show a pulse
  property p_low_when_off;
    (ref_pulse_out & ~ref_out_enable) == '0;
  endproperty
  a_low_when_off: assert property (p_low_when_off) else $error("pulse on disabled output");
  property p_bias_idle;
    (ref_crosspoint_bias & ref_out_enable) == '0;
  endproperty
  a_bias_idle: assert property (p_bias_idle) else $error("bias while driven");
  property p_quiet_after;
    $fell(ref_out_enable[0]) |-> !ref_out_enable[0] [*3];
  endproperty
  a_quiet_after: assert property (p_quiet_after) else $error("output re-enabled after event");
  property p_reset_vals;
    $rose(rst_n) |-> ref_fine_code == '0 && clk3_to_pll_en && ref_out_enable == '0 && !pready;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("outputs wrong after reset");
endmodule

bind srg_top srg_assertions #(
  .NUM_CH (NUM_CH),
  .NUM_REF(NUM_REF)
) u_srg_chk (
  .clk, .rst_n, .psel, .penable, .paddr, .prdata, .pready, .pslverr, .clk3_to_pll_en,
  .ref_pulse_out, .ref_out_enable, .ref_crosspoint_bias, .ref_fine_code
);
`default_nettype wire

// ### tb/srg_conv_model.sv
// converter-side receiver: counts reference pulses of one output per event
`default_nettype none
module srg_conv_model
  import srg_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       pulse,
  input  wire logic       en,
  output logic      [7:0] seen_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pulse_q;
  logic en_q;
  logic rise;
  // an undriven line carries no pulse, so edges only count while enabled
  assign rise = en && pulse && !pulse_q;
  // count restarts when an event switches the output on; held afterwards for the bench
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pulse_q  <= 1'b0;
      en_q     <= 1'b0;
      seen_cnt <= 8'h00;
    end else begin
      pulse_q  <= pulse;
      en_q     <= en;
      seen_cnt <= (en && !en_q) ? 8'(rise) : seen_cnt + 8'(rise);
    end
  end
endmodule
`default_nettype wire

// ### tb/sysref_pulse_gen_phase_delay_tb.sv
// self-checking bench for the reference pulse generator
`default_nettype none
module sysref_pulse_gen_phase_delay_tb
  import srg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x;} srg_row_s;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, er;
  logic        vco_tick, vcxo_tick, ext_trigger_pin, clk3_in, clk3_to_pll_en;
  logic [7:0]  paddr, seen_cnt;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  channel_clock_out, ref_pulse_out, ref_out_enable, ref_crosspoint_bias;
  logic [11:0] ref_fine_code;
  int          bad_count, n_tests, hi, wk;
  int          lat[3];
  // reset reads, then write and read back
  srg_row_s    rows[8] = '{'{1'b0, 8'h00, 32'h0, 32'h0}, '{1'b0, 8'h04, 32'h0, 32'h00010102},
    '{1'b0, 8'h10, 32'h0, 32'h1}, '{1'b0, 8'h20, 32'h0, 32'h0}, '{1'b1, 8'h00, 32'h1F, 32'h0},
    '{1'b0, 8'h00, 32'h0, 32'h1F}, '{1'b1, 8'h10, 32'hFF04, 32'h0}, '{1'b0, 8'h10, 32'h0, 32'hFF04}};
  logic [7:0]  fine_ps[8] = '{8'h00, 8'h19, 8'h32, 8'h4B, 8'h55, 8'h6E, 8'h87, 8'hA0};
  logic [7:0]  cnts[3] = '{8'h01, 8'h05, 8'hFF};

  srg_top DUT (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .vco_tick, .vcxo_tick, .ext_trigger_pin, .clk3_in, .clk3_to_pll_en, .channel_clock_out,
    .ref_pulse_out, .ref_out_enable, .ref_crosspoint_bias, .ref_fine_code);
  srg_conv_model u_conv (.clk, .rst_n, .pulse(ref_pulse_out[0]), .en(ref_out_enable[0]), .seen_cnt);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic stall;
    bad_count++;
    $display("MISMATCH wait expected done seen timeout");
    end_of_test;
  endtask

  // one transfer; called just after a rising edge, leaves one idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 16) stall;
    @(posedge clk);
  endtask

  task automatic wait_en(input logic v);
    int k;
    k = 0;
    while (ref_out_enable[0] !== v && k < 2000) begin
      @(posedge clk);
      k++;
    end
    wk = k;
    if (k >= 2000) stall;
  endtask

  initial begin
    {rst_n, psel, penable, pwrite, vcxo_tick, ext_trigger_pin, clk3_in} = '0;
    {paddr, pwdata} = '0;
    vco_tick = 1'b1; // oscillator tick every cycle keeps events short
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk("pslverr", 32'(er), 32'h0);
      if (!rows[i].w) chk("reg", rd, rows[i].x);
    end
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, 8'h20, 32'(c << 3));
      apb(1'b0, 8'h20, 32'h0);
      chk("fine", rd, {16'h0, fine_ps[c], 2'b00, 3'(c), 3'b000});
      chk("fine_code", 32'(ref_fine_code[2:0]), 32'(c));
    end
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped_err", 32'(er), 32'h1);
    chk("unmapped_data", rd, 32'h0);
    $display("test registers done");
    // channel 1 held off by half its period must run as the inverse of channel 0
    apb(1'b1, 8'h10, 32'h0004);
    apb(1'b1, 8'h14, 32'h0204);
    apb(1'b1, 8'h00, 32'h30);
    repeat (8) @(posedge clk);
    hi = 0;
    for (int t = 0; t < 8; t++) begin
      chk("ch_inverse", 32'(channel_clock_out[1]), 32'(!channel_clock_out[0]));
      hi += int'(channel_clock_out[0]);
      @(posedge clk);
    end
    chk("ch_duty", hi, 32'h4);
    // with bypass the channels follow the idle vcxo tick, then run on it
    apb(1'b1, 8'h00, 32'h11);
    repeat (2) @(posedge clk);
    rd = 32'(channel_clock_out);
    for (int t = 0; t < 8; t++) begin
      @(posedge clk);
      chk("bypass_hold", 32'(channel_clock_out), rd);
    end
    vcxo_tick <= 1'b1;
    repeat (2) @(posedge clk);
    hi = 0;
    for (int t = 0; t < 8; t++) begin
      hi += int'(channel_clock_out[0]);
      @(posedge clk);
    end
    chk("bypass_run", hi, 32'h4);
    vcxo_tick <= 1'b0;
    $display("test channel done");
    // ref 0 as pulse output resting at crosspoint
    apb(1'b1, 8'h20, 32'hC0);
    apb(1'b1, 8'h00, 32'h10);
    repeat (3) @(posedge clk);
    chk("idle_bias", 32'(ref_crosspoint_bias[0]), 32'h1);
    foreach (cnts[j]) begin
      apb(1'b1, 8'h04, {16'h0001, cnts[j], 8'h02});
      apb(1'b1, 8'h00, 32'h110);
      wait_en(1'b1);
      wait_en(1'b0);
      chk("pulses", 32'(seen_cnt), 32'(cnts[j]));
      repeat (3) @(posedge clk);
      chk("rest_bias", 32'(ref_crosspoint_bias[0]), 32'h1);
    end
    $display("test counted done");
    // restart fixes the sync phase so the event latency only moves with the delays
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, 8'h20, (m == 1) ? 32'hC3 : 32'hC0);
      apb(1'b1, 8'h04, (m == 2) ? 32'h01010102 : 32'h00010102);
      apb(1'b1, 8'h00, 32'h30);
      apb(1'b1, 8'h00, 32'h110);
      wait_en(1'b1);
      lat[m] = wk;
      wait_en(1'b0);
    end
    chk("coarse_step", 32'(lat[1] - lat[0]), 32'h3);
    chk("global_step", 32'(lat[2] - lat[0]), 32'h8);
    $display("test delay done");
    apb(1'b1, 8'h04, 32'h00010202);
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, 8'h00, 32'h12 | 32'(s << 3));
      apb(1'b1, 8'h00, 32'h112 | 32'(s << 3));
      // the unselected input must not start the event
      if (s) ext_trigger_pin <= 1'b1;
      else clk3_in <= 1'b1;
      repeat (10) @(posedge clk);
      chk("armed_idle", 32'(ref_out_enable[0]), 32'h0);
      chk("clk3_pll", 32'(clk3_to_pll_en), 32'(s == 0));
      if (s) clk3_in <= 1'b1;
      else ext_trigger_pin <= 1'b1;
      wait_en(1'b1);
      wait_en(1'b0);
      chk("ext_pulses", 32'(seen_cnt), 32'h2);
      ext_trigger_pin <= 1'b0;
      clk3_in         <= 1'b0;
    end
    $display("test external done");
    apb(1'b1, 8'h00, 32'h14);
    apb(1'b1, 8'h00, 32'h114);
    repeat (100) @(posedge clk);
    chk("cont_on", 32'(ref_out_enable[0]), 32'h1);
    chk("cont_many", 32'(seen_cnt > 8'h14), 32'h1);
    apb(1'b1, 8'h00, 32'h214);
    wait_en(1'b0);
    $display("test continuous done");
    // reset in mid-event must abort it and restore defaults
    apb(1'b1, 8'h00, 32'h10);
    apb(1'b1, 8'h04, 32'h0001FF02);
    apb(1'b1, 8'h00, 32'h110);
    wait_en(1'b1);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("reset_off", 32'(ref_out_enable[0]), 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    chk("reset_cfg", rd, 32'h00010102);
    $display("test reset done");
    end_of_test;
  end
endmodule
`default_nettype wire
